// ===== tb_top.sv
// tb_top: self-checking bench for tbd_detector.
// assumes tbd_src_model feeds samples and the bench drains results.
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  tbd_pkg::tbd_cfg_t cfg = '0;
  logic sweep_start = 1'b0;
  logic res_ready = 1'b1;
  logic slow = 1'b0;
  logic s_valid, s_ready, res_valid, busy, cfg_error, sweep_done;
  logic [15:0] s_data;
  tbd_pkg::tbd_result_t res;
  logic [31:0] bucket_samples, bucket_hz;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_done = 0;
  logic [15:0] smp[$];
  always #10 mclk = ~mclk;
  tbd_detector u_tbd_detector (.mclk(mclk), .rst(rst), .cfg(cfg), .sweep_start(sweep_start),
    .s_valid(s_valid), .s_data(s_data), .s_ready(s_ready), .res_valid(res_valid), .res(res),
    .res_ready(res_ready), .busy(busy), .cfg_error(cfg_error), .sweep_done(sweep_done),
    .bucket_samples(bucket_samples), .bucket_hz(bucket_hz));
  tbd_src_model u_tbd_src_model (.mclk(mclk), .rst(rst), .slow(slow), .s_valid(s_valid),
    .s_data(s_data), .s_ready(s_ready));
  // ********
  // checking and closing
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (sweep_done === 1'b1)
      n_done++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  // ********
  // scenarios
  // ********
  task automatic start(input logic [1:0] m, input logic [15:0] p, input logic [31:0] ss);
    @(posedge mclk);
    cfg <= '{tbd_pkg::tbd_mode_t'(m), p, 32'h0000_0300, ss};
    sweep_start <= 1'b1;
    @(posedge mclk);
    sweep_start <= 1'b0;
  endtask
  task automatic refuse;
    start(2'h1, 16'h0000, 32'h0000_0008);
    @(negedge mclk);
    check(cfg_error, 1'b1);
    check(busy, 1'b0);
    start(2'h1, 16'h9c41, 32'h0000_0008);
    @(negedge mclk);
    check(cfg_error, 1'b0);
    check(busy, 1'b1);
    // abort the long sweep by a reset while its buckets are still being sized
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(busy, 1'b0);
    check(s_ready, 1'b0);
    start(2'h1, 16'h9c42, 32'h0000_0008);
    @(negedge mclk);
    check(cfg_error, 1'b1);
    check(busy, 1'b0);
  endtask
  task automatic sweep(input logic [1:0] m, input logic [15:0] p, input logic [31:0] ss,
                       input int stall);
    int l, d, k, i, w, d0;
    logic [15:0] mx, mn, hd, e, v;
    logic ro, fe;
    d = (p == 1) ? 1 : p - 1;
    l = ss / d;
    d0 = n_done;
    hd = 16'h0000;
    smp = {};
    for (k = 0; k < p; k++)
      for (i = 0; i < l; i++)
      begin
        v = (k % 4 == 0) ? 16'(k * 16 + i) : (k % 4 == 1) ? 16'(200 - i * 3) :
            16'((i * 37 + k * 13) % 50 + ((k % 4 == 2) ? 100 : 0));
        smp.push_back(v);
        u_tbd_src_model.push(v);
      end
    @(posedge mclk);
    res_ready <= (stall == 0);
    start(m, p, ss);
    if (stall != 0)
      start(2'h2, p, ss);
    @(negedge mclk);
    check(cfg_error, 1'b0);
    if (stall != 0)
    begin
      repeat (stall) @(posedge mclk);
      @(negedge mclk);
      check(s_ready, 1'b0);
      @(posedge mclk);
      res_ready <= 1'b1;
    end
    for (k = 0; k < p; k++)
    begin
      mx = 16'h0000;
      mn = 16'hffff;
      ro = 1'b0;
      fe = 1'b0;
      for (i = 0; i < l; i++)
      begin
        v = smp[k*l+i];
        if (v > mx) mx = v;
        if (v < mn) mn = v;
        if (i > 0 && v > smp[k*l+i-1]) ro = 1'b1;
        if (i > 0 && v < smp[k*l+i-1]) fe = 1'b1;
      end
      if (m == 2'h0) e = smp[k*l+l/2];
      else if (m == 2'h1) e = mx;
      else if (m == 2'h2) e = mn;
      else if (ro && fe && k % 2 == 0) e = mn;
      else e = (ro && fe && hd > mx) ? hd : mx;
      hd = (ro && fe && k % 2 == 0) ? mx : 16'h0000;
      w = 0;
      do
      begin
        @(negedge mclk);
        w++;
      end
      while (res_valid !== 1'b1 && w < 3000);
      check(res_valid, 1'b1);
      check(res.index, 32'(k));
      check(res.value, e);
      @(posedge mclk);
    end
    w = 0;
    do
    begin
      @(negedge mclk);
      w++;
    end
    while (busy !== 1'b0 && w < 500);
    check(busy, 1'b0);
    check(32'(n_done), 32'(d0 + 1));
    check(bucket_samples, ss / d);
    check(bucket_hz, 32'h0000_0300 / d);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    refuse();
    sweep(2'h1, 16'h0004, 32'h0000_000c, 0);
    sweep(2'h2, 16'h0004, 32'h0000_000d, 0);
    sweep(2'h0, 16'h0003, 32'h0000_000a, 0);
    sweep(2'h0, 16'h0001, 32'h0000_0006, 0);
    slow <= 1'b1;
    sweep(2'h3, 16'h000c, 32'h0000_0037, 0);
    slow <= 1'b0;
    sweep(2'h1, 16'h000c, 32'h0000_0021, 200);
    conclude();
  end
endmodule // tb_top

// ===== tbd_detector.sv
// tbd_detector: reduces envelope samples to one trace value per bucket.
// assumes samples arrive on mclk with valid/ready and trace memory drains results.
//
// Summary of operation
// - bucket frequency width is span divided by trace points minus one, or by one for a single point.
// - bucket samples are sweep samples divided by trace points minus one, or by one for a single point.
// - sample mode keeps only the amplitude at the bucket midpoint.
// - trace points accepted from 1 up to 40001; others refused.
// - positive peak mode outputs the largest sample of each bucket.
// - negative peak mode outputs the smallest sample of each bucket.
// - normal mode tracks max and min; rose and fell means noise.
// - odd noise bucket outputs a maximum, never its minimum.
// - even noise bucket outputs its own minimum.
// - monotonic bucket outputs its maximum whatever the index parity.
// - odd noise bucket outputs larger of own and held previous peak.
// - even noise bucket holds its maximum for the next odd bucket.
`timescale 1ns/10ps
module tbd_detector #(
  parameter int FIFO_DEPTH = tbd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration, taken at sweep_start
  input wire tbd_pkg::tbd_cfg_t cfg,
  input wire logic sweep_start,
  // envelope samples
  input wire logic s_valid,
  input wire logic [tbd_pkg::SAMPLE_W-1:0] s_data,
  output logic s_ready,
  // trace results
  output logic res_valid,
  output tbd_pkg::tbd_result_t res,
  input wire logic res_ready,
  // status
  output logic busy,
  output logic cfg_error,
  output logic sweep_done,
  output logic [tbd_pkg::SWEEP_W-1:0] bucket_samples,
  output logic [tbd_pkg::SPAN_W-1:0] bucket_hz
);

  // ****************************************
  // declarations
  // ****************************************
  localparam int SW = tbd_pkg::SAMPLE_W;
  localparam int PW = tbd_pkg::POINT_W;
  localparam int TW = tbd_pkg::SWEEP_W;

  generate
    if (FIFO_DEPTH < 2)
    begin : g_bad_depth
      $error("tbd_detector: FIFO_DEPTH must be at least 2");
    end
    if (tbd_pkg::SPAN_W != TW)
    begin : g_bad_widths
      $error("tbd_detector: span and sweep widths must match");
    end
  endgenerate

  tbd_pkg::tbd_state_t state;
  tbd_pkg::tbd_state_t next_state;
  tbd_pkg::tbd_mode_t mode;
  logic [PW-1:0] points;
  logic [PW-1:0] bkt_idx;
  logic [TW-1:0] samp_cnt;
  logic [TW-1:0] seg_len;
  logic [SW-1:0] cur_max;
  logic [SW-1:0] cur_min;
  logic [SW-1:0] prev;
  logic [SW-1:0] mid_val;
  logic [SW-1:0] held;
  logic rose;
  logic fell;
  logic div_start;
  logic [TW-1:0] div_divisor;
  logic [TW-1:0] span_q;
  logic [TW-1:0] sweep_q;
  logic sweep_div_done;
  logic fifo_spare;
  logic [TW-1:0] cfg_span;
  logic [TW-1:0] cfg_sweep;
  tbd_pkg::tbd_result_t fifo_in;

  // ****************************************
  // configuration check and bucket sizing
  // ****************************************
  wire pts_ok = (cfg.points >= tbd_pkg::POINTS_MIN)
             && (cfg.points <= tbd_pkg::POINTS_MAX);
  wire start_ok = sweep_start && (state == tbd_pkg::TBD_ST_IDLE) && pts_ok;
  // a single point covers the whole sweep in one interval
  wire [TW-1:0] segments = (cfg.points > tbd_pkg::POINTS_MIN)
                         ? TW'(cfg.points - 1'b1)
                         : tbd_pkg::ONE_SEG;

  tbd_divider #(
    .W(TW)
  ) u_span_div (
    .mclk(mclk),
    .rst(rst),
    .start(div_start),
    .dividend(cfg_span),
    .divisor(div_divisor),
    .busy(),
    .done(),
    .quotient(span_q)
  );

  tbd_divider #(
    .W(TW)
  ) u_sweep_div (
    .mclk(mclk),
    .rst(rst),
    .start(div_start),
    .dividend(cfg_sweep),
    .divisor(div_divisor),
    .busy(),
    .done(sweep_div_done),
    .quotient(sweep_q)
  );

  // ****************************************
  // per-sample datapath
  // ****************************************
  wire take = s_valid && s_ready && (state == tbd_pkg::TBD_ST_RUN);
  wire first = (samp_cnt == '0);
  wire last = (samp_cnt == seg_len - 1'b1);
  wire at_mid = (samp_cnt == (seg_len >> 1));
  wire last_bkt = (bkt_idx == points - 1'b1);
  wire odd = bkt_idx[0];

  wire [SW-1:0] next_max = (first || s_data > cur_max) ? s_data : cur_max;
  wire [SW-1:0] next_min = (first || s_data < cur_min) ? s_data : cur_min;
  wire next_rose = !first && (rose || s_data > prev);
  wire next_fell = !first && (fell || s_data < prev);
  wire noise = next_rose && next_fell;
  wire [SW-1:0] next_mid = at_mid ? s_data : mid_val;

  wire [SW-1:0] odd_peak = (next_max > held) ? next_max : held;
  wire [SW-1:0] noise_val = odd ? odd_peak : next_min;
  wire [SW-1:0] normal_val = noise ? noise_val : next_max;

  wire [SW-1:0] result_val =
      (mode == tbd_pkg::TBD_SAMPLE) ? next_mid :
      (mode == tbd_pkg::TBD_POS_PEAK) ? next_max :
      (mode == tbd_pkg::TBD_NEG_PEAK) ? next_min :
      normal_val;

  wire emit = take && last;
  wire hold_peak = (mode == tbd_pkg::TBD_NORMAL) && noise && !odd;

  assign fifo_in.index = bkt_idx;
  assign fifo_in.value = result_val;

  // ****************************************
  // sequencing
  // ****************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      tbd_pkg::TBD_ST_IDLE:
      begin
        if (start_ok)
          next_state = tbd_pkg::TBD_ST_DIV;
      end
      tbd_pkg::TBD_ST_DIV:
      begin
        if (sweep_div_done)
          next_state = tbd_pkg::TBD_ST_RUN;
      end
      tbd_pkg::TBD_ST_RUN:
      begin
        if (emit && last_bkt)
          next_state = tbd_pkg::TBD_ST_IDLE;
      end
      default:
        next_state = tbd_pkg::TBD_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state <= tbd_pkg::TBD_ST_IDLE;
    else
      state <= next_state;
  end

  // latch configuration at sweep start
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode <= tbd_pkg::TBD_SAMPLE;
      points <= tbd_pkg::POINTS_MIN;
      cfg_span <= '0;
      cfg_sweep <= '0;
      div_divisor <= tbd_pkg::ONE_SEG;
      div_start <= 1'b0;
      cfg_error <= 1'b0;
    end
    else
    begin
      div_start <= start_ok;
      if (sweep_start && state == tbd_pkg::TBD_ST_IDLE)
        cfg_error <= !pts_ok;
      if (start_ok)
      begin
        mode <= cfg.mode;
        points <= cfg.points;
        cfg_span <= cfg.span;
        cfg_sweep <= cfg.sweep_samples;
        div_divisor <= segments;
      end
    end
  end

  // bucket length and reported widths
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      seg_len <= tbd_pkg::ONE_SEG;
      bucket_samples <= '0;
      bucket_hz <= '0;
    end
    else if (sweep_div_done)
    begin
      seg_len <= (sweep_q == '0) ? tbd_pkg::ONE_SEG : sweep_q;
      bucket_samples <= sweep_q;
      bucket_hz <= span_q;
    end
  end

  // bucket counters
  always_ff @(posedge mclk)
  begin
    if (rst || start_ok)
    begin
      samp_cnt <= '0;
      bkt_idx <= '0;
    end
    else if (take)
    begin
      samp_cnt <= last ? '0 : samp_cnt + 1'b1;
      if (emit)
        bkt_idx <= bkt_idx + 1'b1;
    end
  end

  // running extremes and direction flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur_max <= '0;
      cur_min <= '0;
      prev <= '0;
      mid_val <= '0;
      rose <= 1'b0;
      fell <= 1'b0;
    end
    else if (take)
    begin
      cur_max <= next_max;
      cur_min <= next_min;
      prev <= s_data;
      mid_val <= next_mid;
      rose <= next_rose;
      fell <= next_fell;
    end
  end

  // remembered peak for the following odd bucket
  always_ff @(posedge mclk)
  begin
    if (rst || start_ok)
      held <= tbd_pkg::HELD_RESET;
    else if (emit)
      held <= hold_peak ? next_max : tbd_pkg::HELD_RESET;
  end

  // ****************************************
  // handshakes and status
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_ready <= 1'b0;
      busy <= 1'b0;
      sweep_done <= 1'b0;
    end
    else
    begin
      s_ready <= (next_state == tbd_pkg::TBD_ST_RUN) && fifo_spare;
      busy <= (next_state != tbd_pkg::TBD_ST_IDLE);
      sweep_done <= emit && last_bkt;
    end
  end

  // ****************************************
  // result buffer
  // ****************************************
  tbd_fifo #(
    .WIDTH(tbd_pkg::RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(emit),
    .in_data(fifo_in),
    .in_ready(),
    .spare(fifo_spare),
    .out_valid(res_valid),
    .out_data(res),
    .out_ready(res_ready)
  );

endmodule // tbd_detector

// ===== tbd_detector_checker.sv
// tbd_detector_checker: timing relations at the detector's ports.
// assumes binding to tbd_detector; sees only its ports.
`timescale 1ns/10ps
module tbd_detector_checker #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration
  input wire tbd_pkg::tbd_cfg_t cfg,
  input wire logic sweep_start,
  // samples
  input wire logic s_valid,
  input wire logic [tbd_pkg::SAMPLE_W-1:0] s_data,
  input wire logic s_ready,
  // results
  input wire logic res_valid,
  input wire tbd_pkg::tbd_result_t res,
  input wire logic res_ready,
  // status
  input wire logic busy,
  input wire logic cfg_error,
  input wire logic sweep_done,
  input wire logic [tbd_pkg::SWEEP_W-1:0] bucket_samples,
  input wire logic [tbd_pkg::SPAN_W-1:0] bucket_hz
);
  wire good = cfg.points != 16'h0000 && cfg.points <= tbd_pkg::POINTS_MAX;
  wire take = sweep_start && !busy;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ********
  // properties
  // ********
  a_start_busy: assert property (take && good |=> busy && !cfg_error)
    else $error("good start did not begin a sweep");
  a_bad_points: assert property (take && !good |=> cfg_error && !busy)
    else $error("bad point count not refused");
  a_error_still: assert property (!sweep_start |=> $stable(cfg_error))
    else $error("error flag moved without a start");
  a_ready_wait: assert property (take && good |=> !s_ready [*8])
    else $error("samples taken before bucket size known");
  a_ready_rise: assert property (take && good |-> ##[2:60] s_ready)
    else $error("sample intake never opened");
  a_idle_ready: assert property (!busy |-> !s_ready)
    else $error("samples taken while idle");
  a_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
    else $error("result changed before taken");
  a_index_step: assert property (res_valid && res_ready ##1 res_valid |->
    res.index == $past(res.index) + 16'h0001 || res.index == 16'h0000)
    else $error("bucket index skipped");
  a_done_pulse: assert property (sweep_done |=> !sweep_done)
    else $error("sweep done longer than one cycle");
  a_busy_cause: assert property ($rose(busy) |-> $past(sweep_start))
    else $error("busy rose without a start");
endmodule // tbd_detector_checker

bind tbd_detector tbd_detector_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.mclk(mclk), .rst(rst),
  .cfg(cfg), .sweep_start(sweep_start), .s_valid(s_valid), .s_data(s_data),
  .s_ready(s_ready), .res_valid(res_valid), .res(res), .res_ready(res_ready), .busy(busy),
  .cfg_error(cfg_error), .sweep_done(sweep_done), .bucket_samples(bucket_samples),
  .bucket_hz(bucket_hz));

// ===== tbd_divider.sv
// tbd_divider: restoring unsigned divider, one quotient bit per clock.
// assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/10ps
module tbd_divider #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  // answer
  output logic busy,
  output logic done,
  output logic [W-1:0] quotient
);

  localparam int CW = $clog2(W + 1);

  generate
    if (W < 2)
    begin : g_bad_width
      $error("tbd_divider: W must be at least 2");
    end
  endgenerate

  logic [W:0] rem;
  logic [W-1:0] den;
  logic [CW-1:0] cnt;
  wire [W:0] shifted = {rem[W-1:0], quotient[W-1]};
  wire [W:0] trial = shifted - {1'b0, den};
  wire fits = ~trial[W];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rem <= '0;
      den <= '0;
      cnt <= '0;
      quotient <= '0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      done <= 1'b0;
      rem <= '0;
      den <= divisor;
      cnt <= CW'(W);
      quotient <= dividend;
    end
    else if (busy)
    begin
      rem <= fits ? trial : shifted;
      quotient <= {quotient[W-2:0], fits};
      cnt <= cnt - 1'b1;
      busy <= (cnt != CW'(1));
      done <= (cnt == CW'(1));
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule // tbd_divider

// ===== tbd_fifo.sv
// tbd_fifo: flip-flop fifo with a registered output stage.
// assumes the reader may stall; spare warns one entry ahead of full.
`timescale 1ns/10ps
module tbd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic spare,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_shape
      $error("tbd_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire push = in_valid && in_ready;
  wire pop = (count != '0) && (!out_valid || out_ready);
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      spare <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready <= next_count < CW'(DEPTH);
      spare <= next_count < CW'(DEPTH - 1);
      if (pop)
      begin
        out_valid <= 1'b1;
        out_data <= mem[rd_ptr];
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule // tbd_fifo

// ===== tbd_pkg.sv
// tbd_pkg: constants, modes, states and carriers of the trace bucket detector.
// assumes one sample clock shared by producer, detector and trace memory.
package tbd_pkg;

  // ****************************************
  // widths and limits
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int POINT_W = 16;
  localparam int SPAN_W = 32;
  localparam int SWEEP_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam logic [POINT_W-1:0] POINTS_MIN = 16'h0001;
  localparam logic [POINT_W-1:0] POINTS_MAX = 16'h9c41;
  localparam logic [SWEEP_W-1:0] ONE_SEG = 32'h0000_0001;
  localparam logic [SAMPLE_W-1:0] HELD_RESET = 16'h0000;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    TBD_SAMPLE = 2'h0,
    TBD_POS_PEAK = 2'h1,
    TBD_NEG_PEAK = 2'h2,
    TBD_NORMAL = 2'h3
  } tbd_mode_t;

  typedef enum logic [1:0] {
    TBD_ST_IDLE = 2'b00,
    TBD_ST_DIV = 2'b01,
    TBD_ST_RUN = 2'b11
  } tbd_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [POINT_W-1:0] index;
    logic [SAMPLE_W-1:0] value;
  } tbd_result_t;

  typedef struct packed {
    tbd_mode_t mode;
    logic [POINT_W-1:0] points;
    logic [SPAN_W-1:0] span;
    logic [SWEEP_W-1:0] sweep_samples;
  } tbd_cfg_t;

  localparam int RESULT_W = $bits(tbd_result_t);

endpackage

// ===== tbd_src_model.sv
// tbd_src_model: envelope sample source with valid/ready and optional stalls.
// assumes the bench queues samples through push before they are needed.
`timescale 1ns/10ps
module tbd_src_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pacing
  input wire logic slow,
  // sample stream
  output logic s_valid = 1'b0,
  output logic [tbd_pkg::SAMPLE_W-1:0] s_data = 16'h0000,
  input wire logic s_ready
);
  logic [tbd_pkg::SAMPLE_W-1:0] q[$];
  logic ph = 1'b0;
  task automatic push(input logic [tbd_pkg::SAMPLE_W-1:0] v);
    q.push_back(v);
  endtask
  // ********
  // offer, hold until taken, then advance
  // ********
  always @(posedge mclk)
  begin
    ph <= ~ph;
    if (rst)
    begin
      s_valid <= 1'b0;
      s_data <= 16'h0000;
    end
    else if (!(s_valid && !s_ready))
    begin
      if (s_valid)
        void'(q.pop_front());
      if (q.size() != 0 && !(slow && ph))
      begin
        s_valid <= 1'b1;
        s_data <= q[0];
      end
      else
      begin
        s_valid <= 1'b0;
        s_data <= ~s_data;
      end
    end
  end
endmodule // tbd_src_model
